// *** autoreload_pwm_params.svh ***
`ifndef AUTORELOAD_PWM_PARAMS_SVH
`define AUTORELOAD_PWM_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 6'h0D
`define IDX_CNT_HI 6'h0E
`define IDX_CNT_LO 6'h0F
`define IDX_RLD_HI 6'h10
`define IDX_RLD_LO 6'h11
`define IDX_OE 6'h12
`define IDX_CSR0 6'h13
`define IDX_DUTY0_HI 6'h17
`define IDX_CAP_HI 6'h1F
`define IDX_CAP_LO 6'h20
`define IDX_XFER 6'h21
`define IDX_BRK 6'h22

// Control and status field positions
`define CTRL_CAP_FLAG 6
`define CTRL_CAP_IRQ_EN 5
`define CTRL_SRC_HI 4
`define CTRL_SRC_LO 3
`define CTRL_WRAP_FLAG 2
`define CTRL_WRAP_IRQ_EN 1
`define CTRL_CMP_IRQ_EN 0
`define CSR_POL 1
`define CSR_MATCH 0
`define BRK_ACTIVE 5
`define BRK_PIN_EN 4

// Reset values and counter limits
`define CNT_RESET 12'h000
`define CNT_TOP 12'hFFF
`define XFER_RESET 1'b1

`endif

// *** autoreload_pwm_pkg.sv ***
package autoreload_pwm_pkg;

   typedef enum logic [1:0] {
      SRC_OFF = 2'b00,
      SRC_LITE = 2'b01,
      SRC_CPU = 2'b10,
      SRC_FAST = 2'b11
   } count_src_t;

endpackage

// *** autoreload_pwm_timer_regs.sv ***
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "autoreload_pwm_params.svh"
// Functional notes
// - Capture flag sets on capture, clears on reading either capture byte.
// - Capture interrupt requested only while capture interrupt enable is set.
// - Source select: off, lite tick, CPU clock, fast clock; resets to off.
// - New source selection takes effect at the next overflow, or at once while the source is off.
// - No PWM output while the lite tick clocks the counter.
// - Wrap flag sets on overflow, clears when control register is read.
// - Overflow interrupt only when its enable is set; enable resets clear.
// - Compare interrupt enable gates match flag interrupts; resets clear.
// - Counter is read-only, resets to zero, counts while a source runs.
// - Overflow reloads counter from the reload value, setting PWM period.
// - Output enable bits hand pins to PWM; zero releases them; reset clears.
// - Polarity bit set inverts the channel output; reset clears.
// - Match flag sets on counter equals duty, clears on channel register read.
// - Break active is read/write, set by low break pin, drives break.
// - Break pin enable lets the pin act; otherwise pin ignored.
// - During break, outputs show the break pattern; pattern resets clear.
// - Duty value sets duty cycle and serves as compare value.
// - Capture input edge copies counter to capture register if flag clear.
// - Transfer bit loads shadow duty and polarity at overflow, then clears.
// - Output goes high at overflow and low on duty match.
// - Break resets counter, reload, duty, duty shadows and output enables.
// - Zero duty value never sets the match flag.
module autoreload_pwm_timer_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Count tick enables, same clock
   input wire logic lite_tick_i,
   input wire logic fast_tick_i,
   // Pins
   input wire logic capture_input_i,
   input wire logic break_n_i,
   output logic [3:0] pwm_o,
   output logic [3:0] pwm_oe_o,
   // Interrupt requests
   output logic wrap_irq_o,
   output logic cap_cmp_irq_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic ack_r;
   logic [31:0] dat_r;
   logic [11:0] cnt_r;
   logic [11:0] cnt_nxt;
   logic [11:0] reload_r;
   logic [11:0] duty_r [4];
   logic [11:0] duty_sh_r [4];
   logic [3:0] pol_r;
   logic [3:0] pol_sh_r;
   logic [3:0] oe_r;
   logic [3:0] match_r;
   logic [3:0] level_r;
   logic [3:0] pattern_r;
   logic [1:0] src_sw_r;
   autoreload_pwm_pkg::count_src_t src_act_r;
   logic cap_flag_r;
   logic cap_irq_en_r;
   logic wrap_flag_r;
   logic wrap_irq_en_r;
   logic cmp_irq_en_r;
   logic brk_r;
   logic brk_pin_en_r;
   logic xfer_r;
   logic [11:0] captured_r;
   logic [2:0] cap_s_r;
   logic [2:0] brk_s_r;
   logic cap_stable_r;
   logic cap_init_r;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic acc;
   logic wr;
   logic rd;
   logic [5:0] idx;
   logic [7:0] wd;
   logic [7:0] rdata;
   logic rd_cap;
   logic rd_ctrl;

   assign acc = cyc_i & stb_i & ~ack_r;
   assign wr = acc & we_i & sel_i[0];
   assign rd = acc & ~we_i;
   assign idx = adr_i[7:2];
   assign wd = dat_i[7:0];
   assign rd_cap = rd & ((idx == `IDX_CAP_HI) | (idx == `IDX_CAP_LO));
   assign rd_ctrl = rd & (idx == `IDX_CTRL);

   // Narrow registers fill the low byte; everything else reads zero
   always_comb begin
      rdata = 8'h00;
      case (idx)
         `IDX_CTRL: rdata = {1'b0, cap_flag_r, cap_irq_en_r, src_sw_r, wrap_flag_r,
                             wrap_irq_en_r, cmp_irq_en_r};
         `IDX_CNT_HI: rdata = {4'h0, cnt_r[11:8]};
         `IDX_CNT_LO: rdata = cnt_r[7:0];
         `IDX_RLD_HI: rdata = {4'h0, reload_r[11:8]};
         `IDX_RLD_LO: rdata = reload_r[7:0];
         `IDX_OE: rdata = {1'b0, oe_r[3], 1'b0, oe_r[2], 1'b0, oe_r[1], 1'b0, oe_r[0]};
         `IDX_CAP_HI: rdata = {4'h0, captured_r[11:8]};
         `IDX_CAP_LO: rdata = captured_r[7:0];
         `IDX_XFER: rdata = {7'h00, xfer_r};
         `IDX_BRK: rdata = {2'b00, brk_r, brk_pin_en_r, pattern_r};
         default: begin
            for (int ch = 0; ch < 4; ch++) begin
               if (idx == 6'(`IDX_CSR0 + ch)) begin
                  rdata = {6'h00, pol_r[ch], match_r[ch]};
               end
               if (idx == 6'(`IDX_DUTY0_HI + 2 * ch)) begin
                  rdata = {4'h0, duty_r[ch][11:8]};
               end
               if (idx == 6'(`IDX_DUTY0_HI + 2 * ch + 1)) begin
                  rdata = duty_r[ch][7:0];
               end
            end
         end
      endcase
   end

   // Answer one cycle after the request; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc;
         if (rd) begin
            dat_r <= {24'h00_0000, rdata};
         end
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic cap_edge;
   logic brk_low;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_s_r <= 3'h0;
         brk_s_r <= 3'h7;
         cap_stable_r <= 1'b0;
         cap_init_r <= 1'b0;
      end else begin
         cap_s_r <= {cap_s_r[1:0], capture_input_i};
         brk_s_r <= {brk_s_r[1:0], break_n_i};
         // First agreement, on the reset zeros, only seeds the level; an input high at reset still gives one edge
         if (cap_s_r[1] == cap_s_r[2]) begin
            cap_stable_r <= cap_s_r[2];
            cap_init_r <= 1'b1;
         end
      end
   end

   assign cap_edge = cap_init_r & (cap_s_r[1] == cap_s_r[2]) & (cap_s_r[2] != cap_stable_r);
   assign brk_low = ~brk_s_r[1] & ~brk_s_r[2];

   // ----------------------------------------
   // Counter and source select
   // ----------------------------------------
   logic tick;
   logic ovf;

   always_comb begin
      case (src_act_r)
         autoreload_pwm_pkg::SRC_OFF: tick = 1'b0;
         autoreload_pwm_pkg::SRC_LITE: tick = lite_tick_i;
         autoreload_pwm_pkg::SRC_CPU: tick = 1'b1;
         autoreload_pwm_pkg::SRC_FAST: tick = fast_tick_i;
         default: tick = 1'b0;
      endcase
   end

   assign ovf = tick & (cnt_r == `CNT_TOP) & ~brk_r;
   assign cnt_nxt = ovf ? reload_r : cnt_r + 12'h001;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= `CNT_RESET;
      end else if (brk_r) begin
         cnt_r <= `CNT_RESET;
      end else if (tick) begin
         cnt_r <= cnt_nxt;
      end
   end

   // A stopped counter never overflows, so a selection made while off applies at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_act_r <= autoreload_pwm_pkg::SRC_OFF;
      end else if (src_act_r == autoreload_pwm_pkg::SRC_OFF || ovf) begin
         src_act_r <= autoreload_pwm_pkg::count_src_t'(src_sw_r);
      end
   end

   // ----------------------------------------
   // Control and status register
   // ----------------------------------------
   logic cap_take;

   assign cap_take = cap_edge & ~cap_flag_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_sw_r <= 2'b00;
         cap_irq_en_r <= 1'b0;
         wrap_irq_en_r <= 1'b0;
         cmp_irq_en_r <= 1'b0;
      end else if (wr && idx == `IDX_CTRL) begin
         src_sw_r <= wd[`CTRL_SRC_HI:`CTRL_SRC_LO];
         cap_irq_en_r <= wd[`CTRL_CAP_IRQ_EN];
         wrap_irq_en_r <= wd[`CTRL_WRAP_IRQ_EN];
         cmp_irq_en_r <= wd[`CTRL_CMP_IRQ_EN];
      end
   end

   // Flags: hardware set wins over a clearing read in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_flag_r <= 1'b0;
         wrap_flag_r <= 1'b0;
      end else begin
         if (cap_take) begin
            cap_flag_r <= 1'b1;
         end else if (rd_cap) begin
            cap_flag_r <= 1'b0;
         end
         if (ovf) begin
            wrap_flag_r <= 1'b1;
         end else if (rd_ctrl) begin
            wrap_flag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         captured_r <= 12'h000;
      end else if (cap_take) begin
         captured_r <= cnt_r;
      end
   end

   // ----------------------------------------
   // Reload, enables, break
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || brk_r) begin
         reload_r <= 12'h000;
         oe_r <= 4'h0;
      end else if (wr) begin
         if (idx == `IDX_RLD_HI) begin
            reload_r[11:8] <= wd[3:0];
         end
         if (idx == `IDX_RLD_LO) begin
            reload_r[7:0] <= wd;
         end
         if (idx == `IDX_OE) begin
            oe_r <= {wd[6], wd[4], wd[2], wd[0]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brk_r <= 1'b0;
         brk_pin_en_r <= 1'b0;
         pattern_r <= 4'h0;
      end else begin
         if (brk_pin_en_r && brk_low) begin
            brk_r <= 1'b1;
         end else if (wr && idx == `IDX_BRK) begin
            brk_r <= wd[`BRK_ACTIVE];
         end
         if (wr && idx == `IDX_BRK) begin
            brk_pin_en_r <= wd[`BRK_PIN_EN];
            pattern_r <= wd[3:0];
         end
      end
   end

   // ----------------------------------------
   // Channels: duty, polarity, shadows, match
   // ----------------------------------------
   logic xfer_wr;

   assign xfer_wr = wr & (idx == `IDX_XFER);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xfer_r <= `XFER_RESET;
      end else if (xfer_wr) begin
         xfer_r <= wd[0];
      end else if (ovf && xfer_r) begin
         xfer_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      for (int ch = 0; ch < 4; ch++) begin
         if (rst_i || brk_r) begin
            duty_r[ch] <= 12'h000;
            duty_sh_r[ch] <= 12'h000;
         end else begin
            if (wr && idx == 6'(`IDX_DUTY0_HI + 2 * ch)) begin
               duty_r[ch][11:8] <= wd[3:0];
            end
            if (wr && idx == 6'(`IDX_DUTY0_HI + 2 * ch + 1)) begin
               duty_r[ch][7:0] <= wd;
            end
            if (ovf && xfer_r) begin
               duty_sh_r[ch] <= duty_r[ch];
            end
         end
      end
   end

   // Upper bits of the channel register are dropped on write
   always_ff @(posedge clk_i) begin
      for (int ch = 0; ch < 4; ch++) begin
         if (rst_i) begin
            pol_r[ch] <= 1'b0;
            pol_sh_r[ch] <= 1'b0;
         end else begin
            if (wr && idx == 6'(`IDX_CSR0 + ch)) begin
               pol_r[ch] <= wd[`CSR_POL];
            end
            if (ovf && xfer_r) begin
               pol_sh_r[ch] <= pol_r[ch];
            end
         end
      end
   end

   // Match is taken on the tick that brings the counter onto the duty value
   always_ff @(posedge clk_i) begin
      for (int ch = 0; ch < 4; ch++) begin
         if (rst_i) begin
            match_r[ch] <= 1'b0;
            level_r[ch] <= 1'b0;
         end else begin
            if (tick && !brk_r && duty_sh_r[ch] != 12'h000
                && cnt_nxt == duty_sh_r[ch]) begin
               match_r[ch] <= 1'b1;
            end else if (rd && idx == 6'(`IDX_CSR0 + ch)) begin
               match_r[ch] <= 1'b0;
            end
            if (ovf) begin
               level_r[ch] <= 1'b1;
            end else if (tick && cnt_nxt == duty_sh_r[ch]) begin
               level_r[ch] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic pwm_allowed;

   assign pwm_allowed = (src_act_r != autoreload_pwm_pkg::SRC_LITE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_o <= 4'h0;
         pwm_oe_o <= 4'h0;
         wrap_irq_o <= 1'b0;
         cap_cmp_irq_o <= 1'b0;
      end else begin
         if (brk_r) begin
            pwm_o <= pattern_r;
            pwm_oe_o <= 4'hF;
         end else begin
            pwm_o <= level_r ^ pol_sh_r;
            pwm_oe_o <= pwm_allowed ? oe_r : 4'h0;
         end
         wrap_irq_o <= wrap_flag_r & wrap_irq_en_r;
         cap_cmp_irq_o <= (cap_flag_r & cap_irq_en_r)
                          | ((|match_r) & cmp_irq_en_r);
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   cap_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_cap && !cap_take |=> !cap_flag_r) else $error("capture flag not cleared by read");
   cap_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cap_irq_en_r && !cmp_irq_en_r ##1 !cap_irq_en_r && !cmp_irq_en_r |=> !cap_cmp_irq_o)
      else $error("capture irq while masked");
   src_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      src_act_r != autoreload_pwm_pkg::SRC_OFF && !ovf |=> $stable(src_act_r))
      else $error("source changed without overflow");
   lite_nopwm_a: assert property (@(posedge clk_i) disable iff (rst_i)
      src_act_r == autoreload_pwm_pkg::SRC_LITE && !brk_r |=> pwm_oe_o == 4'h0)
      else $error("pwm enabled on lite source");
   wrap_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf |=> wrap_flag_r ##1 (wrap_irq_o == $past(wrap_irq_en_r)))
      else $error("wrap flag or irq wrong after overflow");
   wrap_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wrap_irq_o |-> $past(wrap_irq_en_r && wrap_flag_r)) else $error("wrap irq unmasked");
   cmp_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_cmp_irq_o |-> $past((cap_flag_r && cap_irq_en_r) || (|match_r && cmp_irq_en_r)))
      else $error("compare irq without cause");
   cnt_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      src_act_r == autoreload_pwm_pkg::SRC_OFF && !brk_r |=> $stable(cnt_r))
      else $error("counter moved while off");
   cnt_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf |=> cnt_r == $past(reload_r)) else $error("counter not reloaded");
   break_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
      brk_r |=> pwm_o == $past(pattern_r) && pwm_oe_o == 4'hF)
      else $error("break pattern not driven");
   break_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      brk_r |=> cnt_r == `CNT_RESET && reload_r == 12'h000 && oe_r == 4'h0)
      else $error("break did not reset timer");
   cap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_flag_r |=> $stable(captured_r)) else $error("capture overwritten while flag set");
   xfer_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf && xfer_r && !xfer_wr |=> !xfer_r && duty_sh_r[0] == $past(duty_r[0]))
      else $error("shadow transfer wrong");

endmodule

// *** far_side_model.sv ***
`timescale 1ns/1ps
module far_side_model (
   // Clock
   input wire logic clk_i,
   // From the timer
   input wire logic [3:0] pwm_i,
   input wire logic [3:0] pwm_oe_i,
   // Bench commands
   input wire logic cap_pulse_i,
   input wire logic brk_low_i,
   // To the timer and the bench
   output logic capture_input_o,
   output logic break_n_o,
   output logic [3:0] pin_o
);
   logic cap_r;
   initial cap_r = 1'b0;
   // Edges only on command; bench keeps the fast source off meanwhile
   always @(posedge clk_i) begin
      if (cap_pulse_i) begin
         cap_r <= ~cap_r;
      end
   end
   assign capture_input_o = cap_r;
   assign break_n_o = ~brk_low_i;
   // Switch inputs have pull-downs, so a released pin reads low
   assign pin_o = pwm_i & pwm_oe_i;
endmodule

// *** tb_autoreload_pwm_timer_regs.sv ***
`timescale 1ns/1ps
`include "autoreload_pwm_params.svh"
module tb_autoreload_pwm_timer_regs;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, lite_tick_i = 1'b0, fast_tick_i = 1'b0, capture_input_i, break_n_i;
   logic [3:0] pwm_o, pwm_oe_o, pin;
   logic wrap_irq_o, cap_cmp_irq_o, cap_pulse = 1'b0, brk_low = 1'b0;
   logic [7:0] q, c;
   int n_fail = 0, compares = 0, cycles = 0, hi;
   always #4 clk_i = ~clk_i;
   autoreload_pwm_timer_regs autoreload_pwm_timer_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .lite_tick_i(lite_tick_i),
      .fast_tick_i(fast_tick_i), .capture_input_i(capture_input_i),
      .break_n_i(break_n_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
      .wrap_irq_o(wrap_irq_o), .cap_cmp_irq_o(cap_cmp_irq_o));
   far_side_model far_side_model_inst (.clk_i(clk_i), .pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o),
      .cap_pulse_i(cap_pulse), .brk_low_i(brk_low), .capture_input_o(capture_input_i),
      .break_n_o(break_n_i), .pin_o(pin));
   // ---------------------------------------------
   // Bus, compare and closing tasks
   // ---------------------------------------------
   task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk({4'h0, q}, {4'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic meas();
      while (pin[0] !== 1'b0) @(posedge clk_i);
      while (pin[0] !== 1'b1) @(posedge clk_i);
      hi = 0;
      while (pin[0] === 1'b1) begin
         @(posedge clk_i);
         hi++;
      end
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      rd(`IDX_CTRL, 8'h00);
      rd(`IDX_XFER, 8'h01);
      rd(`IDX_CNT_LO, 8'h00);
      rd(6'h3F, 8'h00);
      wb(1'b1, `IDX_CTRL, 8'hE3);
      rd(`IDX_CTRL, 8'h23);
      $display("test reset done");
   endtask
   task automatic t_wrap();
      wb(1'b1, `IDX_RLD_HI, 8'h0F);
      wb(1'b1, `IDX_RLD_LO, 8'h00);
      wb(1'b1, `IDX_CTRL, 8'h12);
      while (wrap_irq_o !== 1'b1) @(posedge clk_i);
      rd(`IDX_CTRL, 8'h16);
      rd(`IDX_CTRL, 8'h12);
      tick(2);
      chk(wrap_irq_o, 1'b0);
      wb(1'b0, `IDX_CNT_LO, 8'h00);
      rd(`IDX_CNT_HI, 8'h0F);
      $display("test wrap done");
   endtask
   task automatic t_pwm();
      wb(1'b1, `IDX_DUTY0_HI, 8'h0F);
      wb(1'b1, `IDX_DUTY0_HI + 6'h01, 8'h40);
      wb(1'b1, `IDX_OE, 8'h01);
      wb(1'b1, `IDX_XFER, 8'h01);
      meas();
      meas();
      chk(hi[11:0], 12'h040);
      chk(pwm_oe_o, 4'h1);
      rd(`IDX_XFER, 8'h00);
      rd(`IDX_CSR0, 8'h01);
      rd(`IDX_CSR0, 8'h00);
      wb(1'b1, `IDX_CSR0, 8'h02);
      wb(1'b1, `IDX_XFER, 8'h01);
      meas();
      meas();
      chk(hi[11:0], 12'h0C0);
      tick(300);
      chk(cap_cmp_irq_o, 1'b0);
      wb(1'b1, `IDX_CTRL, 8'h13);
      tick(2);
      chk(cap_cmp_irq_o, 1'b1);
      rd(`IDX_CSR0, 8'h03);
      $display("test pwm done");
   endtask
   task automatic t_capture();
      wb(1'b1, `IDX_CTRL, 8'h32);
      cap_pulse <= 1'b1;
      @(posedge clk_i);
      cap_pulse <= 1'b0;
      tick(8);
      chk(cap_cmp_irq_o, 1'b1);
      wb(1'b0, `IDX_CNT_LO, 8'h00);
      c = q;
      cap_pulse <= 1'b1;
      @(posedge clk_i);
      cap_pulse <= 1'b0;
      tick(8);
      wb(1'b0, `IDX_CTRL, 8'h00);
      chk(q[6], 1'b1);
      wb(1'b0, `IDX_CAP_LO, 8'h00);
      chk((c - q) < 8'h10, 1'b1);
      rd(`IDX_CAP_HI, 8'h0F);
      wb(1'b0, `IDX_CTRL, 8'h00);
      chk(q[6], 1'b0);
      tick(2);
      chk(cap_cmp_irq_o, 1'b0);
      $display("test capture done");
   endtask
   task automatic t_break();
      wb(1'b1, `IDX_BRK, 8'h0A);
      brk_low <= 1'b1;
      tick(10);
      chk(pwm_oe_o, 4'h1);
      rd(`IDX_BRK, 8'h0A);
      wb(1'b1, `IDX_BRK, 8'h1A);
      tick(10);
      chk(pwm_oe_o, 4'hF);
      chk(pwm_o, 4'hA);
      rd(`IDX_BRK, 8'h3A);
      rd(`IDX_RLD_HI, 8'h00);
      rd(`IDX_OE, 8'h00);
      brk_low <= 1'b0;
      tick(10);
      wb(1'b1, `IDX_BRK, 8'h10);
      rd(`IDX_BRK, 8'h10);
      tick(2);
      chk(pwm_oe_o, 4'h0);
      $display("test break done");
   endtask
   task automatic t_source();
      wb(1'b1, `IDX_CTRL, 8'h00);
      wb(1'b0, `IDX_CNT_LO, 8'h00);
      c = q;
      wb(1'b0, `IDX_CNT_LO, 8'h00);
      chk(q !== c, 1'b1);
      // Drop any stale wrap flag so the poll below sees the next overflow
      wb(1'b0, `IDX_CTRL, 8'h00);
      do wb(1'b0, `IDX_CTRL, 8'h00); while (q[2] !== 1'b1);
      rd(`IDX_CNT_LO, 8'h00);
      rd(`IDX_CNT_HI, 8'h00);
      $display("test source done");
   endtask
   task automatic t_lite();
      wb(1'b1, `IDX_CTRL, 8'h08);
      wb(1'b1, `IDX_OE, 8'h01);
      lite_tick_i <= 1'b1;
      tick(5);
      lite_tick_i <= 1'b0;
      rd(`IDX_CNT_LO, 8'h05);
      chk(pwm_oe_o, 4'h0);
      wb(1'b1, `IDX_CTRL, 8'h18);
      fast_tick_i <= 1'b1;
      tick(4);
      fast_tick_i <= 1'b0;
      rd(`IDX_CNT_LO, 8'h05);
      lite_tick_i <= 1'b1;
      tick(4100);
      lite_tick_i <= 1'b0;
      rd(`IDX_CNT_LO, 8'h00);
      fast_tick_i <= 1'b1;
      tick(3);
      fast_tick_i <= 1'b0;
      rd(`IDX_CNT_LO, 8'h03);
      chk(pwm_oe_o, 4'h1);
      wb(1'b1, `IDX_CNT_LO, 8'hAA);
      rd(`IDX_CNT_LO, 8'h03);
      $display("test lite done");
   endtask
   // ---------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      tick(2);
      rst_i <= 1'b0;
      t_reset();
      t_wrap();
      t_pwm();
      t_capture();
      t_break();
      t_source();
      t_lite();
      conclude();
   end
endmodule
